// File: rtl/abu_top.sv
// address breakpoint unit with classic wishbone register slave
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module abu_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire abu_pkg::abu_cpu_t cpu_i,
    output abu_pkg::abu_brk_t brk_o,
    input wire logic test_high_voltage,
    output logic timer_stop,
    output logic watchdog_disable,
    output logic status_clear_allow,
    output logic irq
);
    import abu_pkg::*;

    abu_state_t state_reg, state_next;
    logic [7:0] addr_hi_reg, addr_lo_reg;
    logic enable_reg, active_reg, wait_flag_reg, clear_en_reg;
    logic [3:0] irq_st_reg, irq_en_reg;
    logic thv_meta_reg, thv_sync_reg;
    logic [7:0] rd_data;

    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = bus_req && wb_we_i && wb_sel_i;
    wire wr_ctrl = wr && (wb_adr_i == ADDR_CTRL);
    wire wr_hi = wr && (wb_adr_i == ADDR_BRK_HI);
    wire wr_lo = wr && (wb_adr_i == ADDR_BRK_LO);
    wire wr_wait = wr && (wb_adr_i == ADDR_WAIT_ST);
    wire wr_flag = wr && (wb_adr_i == ADDR_FLAG_CTL);
    wire wr_iren = wr && (wb_adr_i == ADDR_IRQ_EN);
    wire wr_irclr = wr && (wb_adr_i == ADDR_IRQ_CLR);

    // break event sources; address match idle in stop, software break still taken
    wire match = enable_reg && !cpu_i.in_stop && cpu_i.fetch
        && (cpu_i.addr == {addr_hi_reg, addr_lo_reg});
    wire soft_brk = wr_ctrl && wb_dat_i[BIT_ACTIVE] && !active_reg;
    wire brk_event = match || soft_brk;
    wire wake = brk_event && cpu_i.in_wait;
    wire leave = (state_reg == ST_BREAK) && cpu_i.rti_done;
    wire [3:0] irq_set = {leave, wake, soft_brk, match};

    // state sequencing: pend until instruction boundary, then break
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (brk_event && cpu_i.last_cycle) begin
                    state_next = ST_BREAK;
                end else if (brk_event) begin
                    state_next = ST_PEND;
                end
            end
            ST_PEND: begin
                if (cpu_i.last_cycle) begin
                    state_next = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (cpu_i.rti_done) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_RUN;
        endcase
    end

    // read mux
    always_comb begin
        rd_data = RESET_BYTE;
        case (wb_adr_i)
            ADDR_CTRL: rd_data = {enable_reg, active_reg, 6'h00};
            ADDR_BRK_HI: rd_data = addr_hi_reg;
            ADDR_BRK_LO: rd_data = addr_lo_reg;
            ADDR_WAIT_ST: rd_data = {6'h00, wait_flag_reg, 1'b0};
            ADDR_FLAG_CTL: rd_data = {7'h00, clear_en_reg};
            ADDR_IRQ_ST: rd_data = {4'h0, irq_st_reg};
            ADDR_IRQ_EN: rd_data = {4'h0, irq_en_reg};
            default: rd_data = RESET_BYTE;
        endcase
    end

    // test voltage synchroniser
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            thv_meta_reg <= 1'b0;
            thv_sync_reg <= 1'b0;
        end else begin
            thv_meta_reg <= test_high_voltage;
            thv_sync_reg <= thv_meta_reg;
        end
    end

    // bus answer, one cycle after request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_BYTE;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : RESET_BYTE;
        end
    end

    // address and control registers, stop leaves them untouched
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_hi_reg <= RESET_BYTE;
            addr_lo_reg <= RESET_BYTE;
            enable_reg <= 1'b0;
            clear_en_reg <= 1'b0;
            irq_en_reg <= 4'h0;
        end else begin
            if (wr_hi) addr_hi_reg <= wb_dat_i;
            if (wr_lo) addr_lo_reg <= wb_dat_i;
            if (wr_ctrl) enable_reg <= wb_dat_i[BIT_ENABLE];
            if (wr_flag) clear_en_reg <= wb_dat_i[BIT_CLEAR_EN];
            if (wr_iren) irq_en_reg <= wb_dat_i[3:0];
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            wait_flag_reg <= 1'b0;
            irq_st_reg <= 4'h0;
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
            if (brk_event) active_reg <= 1'b1;
            else if (wr_ctrl && !wb_dat_i[BIT_ACTIVE]) active_reg <= 1'b0;
            if (wake) wait_flag_reg <= 1'b1;
            else if (wr_wait && !wb_dat_i[BIT_WAIT]) wait_flag_reg <= 1'b0;
            irq_st_reg <= irq_set | (irq_st_reg & ~(wr_irclr ? wb_dat_i[3:0] : 4'h0));
        end
    end

    // cpu and system outputs, all registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            brk_o <= '0;
            timer_stop <= 1'b0;
            watchdog_disable <= 1'b0;
            status_clear_allow <= 1'b1;
            irq <= 1'b0;
        end else begin
            brk_o.break_req <= (state_next == ST_PEND) ||
                (state_next == ST_BREAK && state_reg != ST_BREAK);
            brk_o.vector <= cpu_i.monitor_mode ? VEC_MONITOR : VEC_USER;
            brk_o.opcode <= OPC_SOFT_INT;
            timer_stop <= (state_next == ST_BREAK);
            watchdog_disable <= (state_next == ST_BREAK) && thv_sync_reg;
            status_clear_allow <= (state_next != ST_BREAK) || clear_en_reg;
            irq <= |((irq_set | irq_st_reg) & irq_en_reg);
        end
    end
endmodule : abu_top

// File: rtl/abu_pkg.sv
// package for the address breakpoint unit: register map, fields, states, rule summary
// What this block does
// - enabled break and program address equal to break address raises break request
// - break entry uses user vector pair FFFC/FFFD with forced software interrupt opcode
// - in monitor mode break entry uses vector pair FEFC/FEFD instead
// - match on an instruction's last cycle starts break entry at once
// - software writing one to break active bit forces a break
// - break active set by match, cleared by written zero and by reset
// - break enable is bit 7 of control, read/write, reset clears it
// - two byte registers hold break address, both cleared by reset
// - return from interrupt inside break routine ends break state
// - break state stops timer counters
// - break state disables watchdog only with test high voltage on reset pin
// - unit works in wait; break ending wait sets break wait flag, zero write clears
// - address match idle in stop mode (software break still taken), registers keep their contents
// - status bits clear during break only when clear flag enable is set
package abu_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_BRK_HI = 4'h1;
    localparam logic [3:0] ADDR_BRK_LO = 4'h2;
    localparam logic [3:0] ADDR_WAIT_ST = 4'h3;
    localparam logic [3:0] ADDR_FLAG_CTL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h7;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_WAIT = 1;
    localparam int BIT_CLEAR_EN = 0;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_SOFT = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_EXIT = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] VEC_USER = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
    localparam logic [7:0] OPC_SOFT_INT = 8'h83;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_PEND = 2'b01,
        ST_BREAK = 2'b10
    } abu_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic last_cycle;
        logic rti_done;
        logic in_wait;
        logic in_stop;
        logic monitor_mode;
    } abu_cpu_t;
    typedef struct packed {
        logic break_req;
        logic [15:0] vector;
        logic [7:0] opcode;
    } abu_brk_t;
endpackage : abu_pkg

// File: verification/abu_assertions.sv
// port checker for the address breakpoint unit
`timescale 1ns/1ns
module abu_assertions (
    input wire logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire abu_pkg::abu_cpu_t cpu_i,
    input wire abu_pkg::abu_brk_t brk_o,
    input wire logic timer_stop, watchdog_disable, status_clear_allow
);
    import abu_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // bus answer timing, then break request and break state relations
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_vec; brk_o.break_req |-> brk_o.opcode == OPC_SOFT_INT &&
        brk_o.vector == (cpu_i.monitor_mode ? VEC_MONITOR : VEC_USER); endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_start; brk_o.break_req && cpu_i.last_cycle && !timer_stop |=> timer_stop; endproperty
    a_start: assert property (p_start) else $error("break late");
    property p_hold; brk_o.break_req && !cpu_i.last_cycle && !timer_stop |=> brk_o.break_req;
    endproperty
    a_hold: assert property (p_hold) else $error("request lost");
    property p_rti; timer_stop && cpu_i.rti_done |-> ##[1:2] !timer_stop; endproperty
    a_rti: assert property (p_rti) else $error("break kept");
    property p_wd; watchdog_disable |-> timer_stop; endproperty
    a_wd: assert property (p_wd) else $error("watchdog off");
    property p_clr; !timer_stop && !$past(timer_stop) |-> status_clear_allow; endproperty
    a_clr: assert property (p_clr) else $error("clear blocked");
    property p_stop; cpu_i.in_stop && !brk_o.break_req |=> !brk_o.break_req; endproperty
    a_stop: assert property (p_stop) else $error("break in stop");
endmodule : abu_assertions
bind abu_top abu_assertions i_chk(.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_i(cpu_i), .brk_o(brk_o),
    .timer_stop(timer_stop), .watchdog_disable(watchdog_disable),
    .status_clear_allow(status_clear_allow));

// File: verification/abu_cpu_model.sv
// cpu sequencer model that steps the program address
`timescale 1ns/1ns
module abu_cpu_model (
    input wire logic ref_clk, rst_n, slow, rti_req, in_wait, in_stop, monitor_mode,
    input wire abu_pkg::abu_brk_t breakpoint_unit,
    output abu_pkg::abu_cpu_t cpu
);
    import abu_pkg::*;
    logic [1:0] cyc_reg;
    logic [15:0] pc_reg;
    wire last = slow ? (cyc_reg == 2'd2) : 1'b1; // slow instructions take three cycles
    // finish the instruction, then take the break vector
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_reg <= 2'd0;
            pc_reg <= 16'h0100;
        end else begin
            cyc_reg <= last ? 2'd0 : cyc_reg + 2'd1;
            if (last) pc_reg <= breakpoint_unit.break_req ? breakpoint_unit.vector : pc_reg + 16'h0001;
        end
    end
    assign cpu = '{pc_reg, 1'b1, last, rti_req, in_wait, in_stop, monitor_mode};
endmodule : abu_cpu_model

// File: verification/test_abu_top.sv
// testbench for the address breakpoint unit
`timescale 1ns/1ns
module test_abu_top;
    import abu_pkg::*;
    logic ref_clk = 0, rst_n = 0, we = 0, sel = 0, cyc = 0, stb = 0, thv = 0, slow = 0;
    logic return_from_interrupt = 0, wt = 0, stp = 0, mon = 0;
    logic [3:0] adr = 0;
    logic [7:0] dat = 0, rd, dat_o;
    logic [15:0] a;
    logic [31:0] r;
    logic ack, ts, wd, sca, irq;
    abu_cpu_t cpu;
    abu_brk_t breakpoint_unit;
    int err_count = 0, n_checks = 0, seed = 32'h1760_c707;
    abu_top i_dut(.ref_clk(ref_clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .cpu_i(cpu), .brk_o(breakpoint_unit), .test_high_voltage(thv), .timer_stop(ts),
        .watchdog_disable(wd), .status_clear_allow(sca), .irq(irq));
    abu_cpu_model i_cpu(.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .rti_req(return_from_interrupt),
        .in_wait(wt), .in_stop(stp), .monitor_mode(mon), .breakpoint_unit(breakpoint_unit), .cpu(cpu));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(input string s, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        {cyc, stb, sel, we} <= {3'b111, w};
        adr <= ad;
        dat <= d;
        for (int n = 0; n < 20 && ack !== 1'b1; n++) @(posedge ref_clk);
        if (ack !== 1'b1) begin
            err_count++;
            $display("Error ack expected 1 seen %b", ack);
        end
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rdc(input string s, input logic [3:0] ad, input logic [7:0] e);
        wb(1'b0, ad, 8'h00);
        chk(s, {8'h00, e}, {8'h00, rd});
    endtask : rdc
    task automatic wts(input logic v);
        for (int n = 0; n < 400 && ts !== v; n++) @(posedge ref_clk);
        if (ts !== v) begin
            err_count++;
            $display("Error timer_stop expected %b seen %b", v, ts);
        end
    endtask : wts
    task summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // reset values, address bytes, then match breaks in four mode settings, one soft break, and no break in stop
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        for (int i = 0; i < 16; i++) if (i != 7) rdc("reset", i[3:0], 8'h00);
        a = $random(seed);
        wb(1, ADDR_BRK_HI, a[15:8]);
        wb(1, ADDR_BRK_LO, a[7:0]);
        rdc("addr", ADDR_BRK_HI, a[15:8]);
        rdc("addr", ADDR_BRK_LO, a[7:0]);
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            {mon, thv, wt, slow} <= {i[0], i[1], i[0] ^ i[1], r[4]};
            wb(1, ADDR_IRQ_EN, i == 3 ? 8'h00 : 8'h0F);
            a = cpu.addr + 16'd40 + {12'h000, r[3:0]};
            if (i == 4) wb(1, ADDR_CTRL, 8'h40);
            else begin
                wb(1, ADDR_BRK_HI, a[15:8]);
                wb(1, ADDR_BRK_LO, a[7:0]);
                wb(1, ADDR_CTRL, 8'h80);
            end
            for (int n = 0; n < 400 && breakpoint_unit.break_req !== 1'b1; n++) @(posedge ref_clk);
            chk("break req", 16'h0001, {15'h0, breakpoint_unit.break_req});
            chk("vector", mon ? VEC_MONITOR : VEC_USER, breakpoint_unit.vector);
            wts(1);
            wt <= 0;
            rdc("control", ADDR_CTRL, i == 4 ? 8'h40 : 8'hC0);
            rdc("wait", ADDR_WAIT_ST, {6'h00, i[0] ^ i[1], 1'b0});
            rdc("irq st", ADDR_IRQ_ST, {5'h00, i[0] ^ i[1], i == 4, i != 4});
            chk("irq", {15'h0, i != 3}, {15'h0, irq});
            chk("watchdog", {15'h0, i[1]}, {15'h0, wd});
            chk("clr allow", 16'h0000, {15'h0, sca});
            wb(1, ADDR_FLAG_CTL, 8'h01);
            repeat (2) @(posedge ref_clk);
            chk("clr allow", 16'h0001, {15'h0, sca});
            wb(1, ADDR_WAIT_ST, 8'h00);
            rdc("wait", ADDR_WAIT_ST, 8'h00);
            wb(1, ADDR_FLAG_CTL, 8'h00);
            wb(1, ADDR_CTRL, 8'h00);
            @(posedge ref_clk);
            return_from_interrupt <= 1;
            @(posedge ref_clk);
            return_from_interrupt <= 0;
            wts(0);
            chk("break", 16'h0000, {15'h0, ts});
            wb(1, ADDR_IRQ_CLR, 8'hFF);
            repeat (2) @(posedge ref_clk);
            chk("irq", 16'h0000, {15'h0, irq});
            $display("test %0d done", i);
        end
        stp <= 1;
        a = cpu.addr + 16'd20;
        wb(1, ADDR_BRK_HI, a[15:8]);
        wb(1, ADDR_BRK_LO, a[7:0]);
        wb(1, ADDR_CTRL, 8'h80);
        repeat (80) @(posedge ref_clk);
        chk("stop", 16'h0000, {15'h0, ts});
        rdc("stop", ADDR_BRK_LO, a[7:0]);
        stp <= 0;
        $display("test stop done");
        summarize;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize;
    end
endmodule : test_abu_top
